/* rtl/msgobj_defines.vh */
// Register offsets, field positions and reset values of the arbitration block
`ifndef MSGOBJ_DEFINES_VH
`define MSGOBJ_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets, first interface set
// ----------------------------------------------------------------------------
`define ARB_LOW_OFS1      8'h30
`define ARB_HIGH_OFS1     8'h34
`define MSG_CTL_OFS1      8'h38

// ----------------------------------------------------------------------------
// Register byte offsets, second interface set
// ----------------------------------------------------------------------------
`define ARB_LOW_OFS2      8'h90
`define ARB_HIGH_OFS2     8'h94
`define MSG_CTL_OFS2      8'h98

// ----------------------------------------------------------------------------
// Upper arbitration register fields
// ----------------------------------------------------------------------------
`define EXT_ID_BIT        14
`define TRANSFER_WAY_BIT  13
`define HIGH_ID_MSB       12
`define STD_ID_LSB        2

// ----------------------------------------------------------------------------
// Message control register fields
// ----------------------------------------------------------------------------
`define NEW_DATA_BIT      15
`define MSG_LOST_BIT      14
`define INT_PEND_BIT      13
`define USE_MASK_BIT      12
`define TX_INT_EN_BIT     11
`define RX_INT_EN_BIT     10
`define REMOTE_ANSWER_BIT 9
`define TX_REQUEST_BIT    8
`define END_OF_BUF_BIT    7
`define DLC_MSB           3

// ----------------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------------
`define ARB_LOW_RST       16'h0000
`define ARB_HIGH_RST      15'h0000
`define MSG_CTL_RST       16'h0000
`define ARB_LOW_WMASK     16'hFFFF
`define ARB_HIGH_WMASK    16'h7FFF
`define MSG_CTL_WMASK     16'hFF8F

`endif

/* rtl/id_match.v */
// Identifier assembly and receive match for one message object
`timescale 1ns/1ns

`include "msgobj_defines.vh"

module id_match (
   input  wire [15:0] low_id,     // Lower arbitration identifier bits
   input  wire [12:0] high_id,    // Upper arbitration identifier bits
   input  wire        ext_id_flag, // Object uses 29-bit identifier
   input  wire [28:0] rx_id,      // Identifier of received frame
   input  wire        rx_ext,     // Received frame is extended
   output reg  [28:0] full_id,    // Assembled object identifier
   output reg         match       // Received identifier equals object's
);

   // -------------------------------------------------------------------------
   // Identifier assembly and compare
   // -------------------------------------------------------------------------
   // Extended objects join both registers, standard ones use the upper field
   always @* begin
      if (ext_id_flag) begin
         full_id = {high_id, low_id};
         match   = rx_ext && (rx_id == full_id);
      end else begin
         // Lower register is ignored for standard identifiers
         full_id = {18'h00000, high_id[`HIGH_ID_MSB:`STD_ID_LSB]};
         match   = !rx_ext && (rx_id[10:0] == full_id[10:0]);
      end
   end

endmodule

/* rtl/msgobj_arb.v */
// Message object arbitration registers with Avalon-MM slave and frame engine
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns

`include "msgobj_defines.vh"

module msgobj_arb (
   input  wire        clock,       // System clock, 10 MHz
   input  wire        rst_b,       // Asynchronous reset, active low
   input  wire [7:0]  address,     // Avalon byte address
   input  wire        read,        // Avalon read request
   input  wire        write,       // Avalon write request
   input  wire [31:0] writedata,   // Avalon write data
   input  wire [3:0]  byteenable,  // Avalon byte lanes
   output reg  [31:0] readdata,    // Avalon read data
   output reg         waitrequest, // Avalon stall, low marks the answer
   input  wire        rx_valid,    // One-cycle pulse: frame received
   input  wire [28:0] rx_id,       // Received identifier
   input  wire        rx_ext,      // Received frame is extended
   input  wire        rx_remote,   // Received frame is a remote frame
   input  wire [3:0]  rx_dlc,      // Received data length code
   input  wire        tx_done,     // One-cycle pulse: offered frame sent
   output reg         tx_valid,    // Frame offered to the bus engine
   output reg  [28:0] tx_id,       // Identifier of offered frame
   output reg         tx_ext,      // Offered frame is extended
   output reg         tx_remote,   // Offered frame is a remote frame
   output reg  [3:0]  tx_dlc,      // Length code of offered frame
   output reg         tx_obj       // Which object the frame belongs to
);

   // -------------------------------------------------------------------------
   // Local constants and helpers
   // -------------------------------------------------------------------------
   localparam OBJ_COUNT = 2; // One object per interface set

   // Merge write data into a 16-bit register under lane and bit masks
   // Bits outside the lane and write masks keep their old value
   function [15:0] merge16;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0]  lanes;
      input [15:0] wmask;
      reg   [15:0] m;
      begin
         m       = {{8{lanes[1]}}, {8{lanes[0]}}} & wmask;
         merge16 = (old_val & ~m) | (new_val & m);
      end
   endfunction

   // -------------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------------
   wire        bus_req;      // Any request present
   wire        wr_commit;    // Write takes effect this edge
   wire        rd_take;      // Read data is captured this edge
   reg         waitrequest_next; // Next stall value
   reg  [31:0] readdata_next;    // Next read data value
   wire [63:0] rd_flat;      // Read words of both objects, zero if missed

   // Reads capture on the first edge of a request, writes commit on the
   // edge where the stall is low, so each access lands exactly once
   assign bus_req   = read | write;
   assign wr_commit = write && !waitrequest;
   assign rd_take   = read && waitrequest;

   // Answer one cycle after the request appears, then stall again
   always @* begin
      waitrequest_next = !(bus_req && waitrequest);
      if (rd_take) begin
         // Unmapped addresses read as zero
         readdata_next = rd_flat[31:0] | rd_flat[63:32];
      end else begin
         readdata_next = readdata;
      end
   end

   // Bus answer flip-flops
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
      end else begin
         waitrequest <= waitrequest_next;
         readdata    <= readdata_next;
      end
   end

   // -------------------------------------------------------------------------
   // Per-object state gathered for the frame engine
   // -------------------------------------------------------------------------
   wire [OBJ_COUNT-1:0]    req_vec;  // Transmit request flags
   wire [OBJ_COUNT-1:0]    way_vec;  // Transfer way, high for transmit
   wire [OBJ_COUNT-1:0]    ext_vec;  // Extended identifier flags
   wire [29*OBJ_COUNT-1:0] id_flat;  // Assembled identifiers
   wire [4*OBJ_COUNT-1:0]  dlc_flat; // Data length codes

   // -------------------------------------------------------------------------
   // Message objects
   // -------------------------------------------------------------------------
   // Both interface sets share one body; only their offsets differ
   genvar g;
   generate
      for (g = 0; g < OBJ_COUNT; g = g + 1) begin : obj
         // Offsets of this interface set
         wire [7:0]  low_ofs;
         wire [7:0]  high_ofs;
         wire [7:0]  ctl_ofs;
         wire        wr_low;        // Software writes lower arbitration
         wire        wr_high;       // Software writes upper arbitration
         wire        wr_ctl;        // Software writes message control
         reg  [15:0] iface_arb_low_reg;      // Lower identifier bits
         reg  [14:0] iface_arb_high_reg;     // Flags and upper identifier
         reg  [15:0] iface_msg_control_reg;  // Message control bits
         reg  [15:0] iface_msg_control_next; // Next message control
         reg  [15:0] ctl_sw;        // Control after software write
         reg  [31:0] rd_word;       // Read word of this object
         wire [15:0] high_merged;   // Upper register after write merge
         wire [28:0] full_id;       // Assembled identifier
         wire        id_hit;        // Received identifier matches
         wire        rx_store;      // Data frame lands in this object
         wire        remote_set;    // Remote frame raises the request
         wire        sent;          // Offered frame of this object sent

         assign low_ofs  = (g == 0) ? `ARB_LOW_OFS1 : `ARB_LOW_OFS2;
         assign high_ofs = (g == 0) ? `ARB_HIGH_OFS1 : `ARB_HIGH_OFS2;
         assign ctl_ofs  = (g == 0) ? `MSG_CTL_OFS1 : `MSG_CTL_OFS2;
         assign wr_low   = wr_commit && (address == low_ofs);
         assign wr_high  = wr_commit && (address == high_ofs);
         assign wr_ctl   = wr_commit && (address == ctl_ofs);
         assign high_merged = merge16({1'b0, iface_arb_high_reg}, writedata[15:0],
                                      byteenable[1:0], `ARB_HIGH_WMASK);

         // Identifier assembly and compare
         // Matching is exact; acceptance masks are not modelled
         id_match u_match (
            .low_id      (iface_arb_low_reg),
            .high_id     (iface_arb_high_reg[`HIGH_ID_MSB:0]),
            .ext_id_flag (iface_arb_high_reg[`EXT_ID_BIT]),
            .rx_id       (rx_id),
            .rx_ext      (rx_ext),
            .full_id     (full_id),
            .match       (id_hit)
         );

         // Data frame for a receive object is stored here
         assign rx_store = rx_valid && id_hit && !rx_remote &&
                           !iface_arb_high_reg[`TRANSFER_WAY_BIT];
         // Remote frame for a transmit object with remote answer enabled raises its request
         assign remote_set = rx_valid && id_hit && rx_remote &&
                             iface_arb_high_reg[`TRANSFER_WAY_BIT] &&
                             iface_msg_control_reg[`REMOTE_ANSWER_BIT];
         // Only the owner of the standing offer sees its completion
         assign sent = tx_done && tx_valid && (tx_obj == ((g == 0) ? 1'b0 : 1'b1));

         // Control next value: software first, hardware sets win last
         always @* begin
            if (wr_ctl) begin
               ctl_sw = merge16(iface_msg_control_reg, writedata[15:0],
                                byteenable[1:0], `MSG_CTL_WMASK);
            end else begin
               ctl_sw = iface_msg_control_reg;
            end
            iface_msg_control_next = ctl_sw;
            // Request drops once the frame has left
            if (sent) begin
               // A request written in the same cycle survives the drop
               if (!(wr_ctl && byteenable[1] && writedata[`TX_REQUEST_BIT])) begin
                  iface_msg_control_next[`TX_REQUEST_BIT] = 1'b0;
               end
               if (iface_msg_control_reg[`TX_INT_EN_BIT]) begin
                  iface_msg_control_next[`INT_PEND_BIT] = 1'b1;
               end
            end
            // A remote frame arriving with the drop still sets the request
            if (remote_set) begin
               iface_msg_control_next[`TX_REQUEST_BIT] = 1'b1;
            end
            // New data overwrites, unread data counts as lost
            if (rx_store) begin
               iface_msg_control_next[`NEW_DATA_BIT] = 1'b1;
               if (iface_msg_control_reg[`NEW_DATA_BIT]) begin
                  iface_msg_control_next[`MSG_LOST_BIT] = 1'b1;
               end
               iface_msg_control_next[`DLC_MSB:0] = rx_dlc;
               if (iface_msg_control_reg[`RX_INT_EN_BIT]) begin
                  iface_msg_control_next[`INT_PEND_BIT] = 1'b1;
               end
            end
         end

         // Object register flip-flops
         always @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               iface_arb_low_reg     <= `ARB_LOW_RST;
               iface_arb_high_reg    <= `ARB_HIGH_RST;
               iface_msg_control_reg <= `MSG_CTL_RST;
            end else begin
               if (wr_low) begin
                  iface_arb_low_reg <= merge16(iface_arb_low_reg, writedata[15:0],
                                               byteenable[1:0], `ARB_LOW_WMASK);
               end
               if (wr_high) begin
                  iface_arb_high_reg <= high_merged[14:0];
               end
               iface_msg_control_reg <= iface_msg_control_next;
            end
         end

         // Read word of this object, zero when the address misses
         // Upper arbitration bit 15 is not stored and reads as zero
         always @* begin
            if (address == low_ofs) begin
               rd_word = {16'h0000, iface_arb_low_reg};
            end else if (address == high_ofs) begin
               rd_word = {17'h00000, iface_arb_high_reg};
            end else if (address == ctl_ofs) begin
               rd_word = {16'h0000, iface_msg_control_reg};
            end else begin
               rd_word = 32'h00000000;
            end
         end

         // Hand state to the shared logic
         assign rd_flat[32*g +: 32] = rd_word;
         assign req_vec[g]          = iface_msg_control_reg[`TX_REQUEST_BIT];
         assign way_vec[g]          = iface_arb_high_reg[`TRANSFER_WAY_BIT];
         assign ext_vec[g]          = iface_arb_high_reg[`EXT_ID_BIT];
         assign id_flat[29*g +: 29] = full_id;
         assign dlc_flat[4*g +: 4]  = iface_msg_control_reg[`DLC_MSB:0];
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Frame engine hand-off
   // -------------------------------------------------------------------------
   reg         sel;          // Object chosen for the next frame
   reg         tx_valid_next;
   reg  [28:0] tx_id_next;
   reg         tx_ext_next;
   reg         tx_remote_next;
   reg  [3:0]  tx_dlc_next;
   reg         tx_obj_next;

   // The offer is frozen while it stands, so a request on the other
   // object waits until the bus engine reports the frame sent.
   // A receive object with a request asks for its data with a
   // remote frame carrying its own identifier and length code.
   // Offer one frame at a time, first object has priority
   always @* begin
      sel            = !req_vec[0];
      tx_valid_next  = tx_valid;
      tx_id_next     = tx_id;
      tx_ext_next    = tx_ext;
      tx_remote_next = tx_remote;
      tx_dlc_next    = tx_dlc;
      tx_obj_next    = tx_obj;
      if (tx_valid) begin
         // Offer stands until the engine reports it sent
         if (tx_done) begin
            tx_valid_next = 1'b0;
         end
      end else if (|req_vec) begin
         tx_valid_next  = 1'b1;
         tx_obj_next    = sel;
         tx_id_next     = id_flat[29*sel +: 29];
         tx_ext_next    = ext_vec[sel];
         // Receive objects ask with a remote frame, transmit send data
         tx_remote_next = !way_vec[sel];
         tx_dlc_next    = dlc_flat[4*sel +: 4];
      end
   end

   // Frame offer flip-flops
   // Fields load only when a new offer starts, then hold
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_valid  <= 1'b0;
         tx_id     <= 29'h00000000;
         tx_ext    <= 1'b0;
         tx_remote <= 1'b0;
         tx_dlc    <= 4'h0;
         tx_obj    <= 1'b0;
      end else begin
         tx_valid  <= tx_valid_next;
         tx_id     <= tx_id_next;
         tx_ext    <= tx_ext_next;
         tx_remote <= tx_remote_next;
         tx_dlc    <= tx_dlc_next;
         tx_obj    <= tx_obj_next;
      end
   end

endmodule

/* testbench/msgobj_arb_properties.sv */
// Port-level assertions for the message object arbitration block
`timescale 1ns/1ns
`include "msgobj_defines.vh"
module msgobj_arb_properties (
   input wire        clock,       // System clock
   input wire        rst_b,       // Reset, active low
   input wire [7:0]  address,     // Bus address
   input wire        read,        // Bus read
   input wire        write,       // Bus write
   input wire [31:0] writedata,   // Bus write data
   input wire [3:0]  byteenable,  // Bus lanes
   input wire [31:0] readdata,    // Bus read data
   input wire        waitrequest, // Bus stall
   input wire        tx_done,     // Frame sent
   input wire        tx_valid,    // Frame offered
   input wire [28:0] tx_id,       // Offered identifier
   input wire        tx_ext,      // Offered format
   input wire        tx_obj       // Offering object
);
   // ------------------------------------------------------------------------
   // Helpers and sequences
   // ------------------------------------------------------------------------
   wire mapped = address == `ARB_LOW_OFS1 || address == `ARB_HIGH_OFS1 ||
                 address == `MSG_CTL_OFS1 || address == `ARB_LOW_OFS2 ||
                 address == `ARB_HIGH_OFS2 || address == `MSG_CTL_OFS2;
   wire req_commit = write && !waitrequest && byteenable[1] && writedata[`TX_REQUEST_BIT] &&
                     (address == `MSG_CTL_OFS1 || address == `MSG_CTL_OFS2);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence bus_req;
      (read || write) && waitrequest;
   endsequence
   sequence one_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   bus_answer_a: assert property (bus_req |=> one_answer)
      else $error("bus answer not a single cycle");
   unmapped_zero_a: assert property (read && waitrequest && !mapped |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (readdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   request_offer_a: assert property (req_commit && !tx_valid |-> ##[1:2] tx_valid)
      else $error("request not offered");
   offer_hold_a: assert property (tx_valid && !tx_done |=>
      tx_valid && $stable(tx_id) && $stable(tx_obj))
      else $error("offer changed before sent");
   offer_drop_a: assert property (tx_valid && tx_done |=> !tx_valid)
      else $error("offer kept after sent");
   std_upper_a: assert property (tx_valid && !tx_ext |-> tx_id[28:11] == 18'h0)
      else $error("standard id upper bits set");
   reset_idle_a: assert property ($rose(rst_b) |->
      readdata == 32'h0 && !tx_valid && waitrequest)
      else $error("state not idle after reset");
endmodule

bind msgobj_arb msgobj_arb_properties msgobj_arb_properties_inst (
   .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .tx_done(tx_done), .tx_valid(tx_valid), .tx_id(tx_id),
   .tx_ext(tx_ext), .tx_obj(tx_obj)
);

/* testbench/can_far_node.sv */
// Far-side bus engine model: acknowledges offers and injects received frames
`timescale 1ns/1ns
module can_far_node (
   input  wire         clock,     // System clock
   input  wire         rst_b,     // Reset, active low
   input  wire         tx_valid,  // Offer from the block
   output logic        tx_done,   // Offer sent
   output logic        rx_valid,  // Frame received pulse
   output logic [28:0] rx_id,     // Received identifier
   output logic        rx_ext,    // Received format
   output logic        rx_remote, // Received remote frame
   output logic [3:0]  rx_dlc     // Received length code
);
   logic       hold;     // Stall acknowledge while set
   logic [2:0] wait_cnt; // Cycles the offer has stood
   logic [2:0] wait_lim; // Acknowledge delay, prompt or slow
   // Quiet receive side at time zero
   initial begin
      hold = 1'b0;
      rx_valid = 1'b0;
      {rx_id, rx_ext, rx_remote, rx_dlc} = '0;
   end
   // Acknowledge each offer after a delay (fixed for the first offer after reset, random after that), one pulse
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_done <= 1'b0;
         wait_cnt <= 3'h0;
         wait_lim <= 3'h1;
      end else if (tx_valid && !tx_done && !hold) begin
         if (wait_cnt == wait_lim) begin
            tx_done <= 1'b1;
            wait_cnt <= 3'h0;
            wait_lim <= 3'($urandom % 5);
         end else wait_cnt <= wait_cnt + 3'h1;
      end else tx_done <= 1'b0;
   end
   // One received frame; fields go to the inverse afterwards
   task automatic send(input logic [28:0] id, input logic ext, rem, input logic [3:0] dlc);
      @(posedge clock);
      rx_valid <= 1'b1;
      {rx_id, rx_ext, rx_remote, rx_dlc} <= {id, ext, rem, dlc};
      @(posedge clock);
      rx_valid <= 1'b0;
      {rx_id, rx_ext, rx_remote, rx_dlc} <= ~{id, ext, rem, dlc};
   endtask
endmodule

/* testbench/msgobj_arb_tb.sv */
// Self-checking bench for the message object arbitration block
`timescale 1ns/1ns
`include "msgobj_defines.vh"
module msgobj_arb_tb;
   logic        clock, rst_b, read, write, waitrequest;   // Clock, reset, bus control
   logic        tx_done, tx_valid, tx_ext, tx_remote, tx_obj; // Offer handshake
   logic        rx_valid, rx_ext, rx_remote;             // Receive strobes
   logic [7:0]  address;                                 // Bus address
   logic [31:0] writedata, readdata, q;                  // Bus data, last read
   logic [3:0]  byteenable, rx_dlc, tx_dlc, dlc;         // Lanes, length codes
   logic [28:0] rx_id, tx_id;                            // Identifiers
   logic [15:0] lo;                                      // Random lower id
   logic [12:0] hi;                                      // Random upper id
   int          mismatches = 0;                          // Failed compares
   int          total_checks = 0;                        // All compares
   logic [7:0]  offs [6] = '{`ARB_LOW_OFS1, `ARB_HIGH_OFS1, `MSG_CTL_OFS1,
                             `ARB_LOW_OFS2, `ARB_HIGH_OFS2, `MSG_CTL_OFS2};
   // ------------------------------------------------------------------------
   // Design, partner, clock
   // ------------------------------------------------------------------------
   msgobj_arb msgobj_arb_inst (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ext(rx_ext),
      .rx_remote(rx_remote), .rx_dlc(rx_dlc), .tx_done(tx_done), .tx_valid(tx_valid),
      .tx_id(tx_id), .tx_ext(tx_ext), .tx_remote(tx_remote), .tx_dlc(tx_dlc), .tx_obj(tx_obj));
   can_far_node can_far_node_inst (.clock(clock), .rst_b(rst_b), .tx_valid(tx_valid),
      .tx_done(tx_done), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ext(rx_ext),
      .rx_remote(rx_remote), .rx_dlc(rx_dlc));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // ------------------------------------------------------------------------
   // Tasks and expectation functions
   // ------------------------------------------------------------------------
   function automatic logic [28:0] ext_id(input logic [12:0] h, input logic [15:0] l);
      return {h, l};
   endfunction
   function automatic logic [28:0] std_id(input logic [12:0] h);
      return {18'h0, h[12:2]};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {16'h0, d};
      byteenable <= 4'h3;
      // Only the watchdog ends a wait that never sees the answer
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 16'h0);
      check(what, q, exp);
   endtask
   task automatic wait_tx(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (tx_valid !== v && n < 40);
      check("offer state", {31'h0, tx_valid}, {31'h0, v});
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      complete_run();
   end
   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      {read, write, rst_b, address, writedata, byteenable} = '0;
      void'($urandom(32'h2669));
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      foreach (offs[i]) rd(offs[i], 32'h0, "reset value");
      rd(8'h3C, 32'h0, "unmapped read");
      for (int i = 0; i < 2; i++) begin
         lo = 16'($urandom);
         bus(1'b1, offs[3*i+1], lo);
         rd(offs[3*i+1], {17'h0, lo[14:0]}, "upper arbitration");
         bus(1'b1, offs[3*i+2], lo & 16'hFEFF);
         rd(offs[3*i+2], {16'h0, lo & 16'hFE8F}, "message control");
         bus(1'b1, offs[3*i+2], 16'h0);
      end
      $display("test registers done");
      // Object 0 extended, object 1 standard transmit
      for (int i = 0; i < 2; i++) begin
         lo = 16'($urandom);
         hi = 13'($urandom);
         dlc = 4'($urandom % 9);
         can_far_node_inst.hold <= 1'b1;
         bus(1'b1, offs[3*i], lo);
         bus(1'b1, offs[3*i+1], {1'b0, i == 0, 1'b1, hi});
         bus(1'b1, offs[3*i+2], {12'h010, dlc});
         wait_tx(1'b1);
         check("offer id", tx_id, i == 0 ? ext_id(hi, lo) : std_id(hi));
         check("offer fields", {tx_ext, tx_remote, tx_obj, tx_dlc},
               {i == 0, 1'b0, i[0], dlc});
         can_far_node_inst.hold <= 1'b0;
         wait_tx(1'b0);
         rd(offs[3*i+2], {28'h0, dlc}, "request cleared");
      end
      $display("test transmit done");
      // Receive object 0: foreign id and wrong format ignored, match stored
      bus(1'b1, offs[1], {3'b010, hi});
      bus(1'b1, offs[0], lo);
      // Drop the length code left from the transmit test
      bus(1'b1, offs[2], 16'h0);
      can_far_node_inst.send(ext_id(hi, lo) ^ 29'h1, 1'b1, 1'b0, dlc);
      can_far_node_inst.send(ext_id(hi, lo), 1'b0, 1'b0, dlc);
      rd(offs[2], 32'h0, "foreign frame ignored");
      can_far_node_inst.send(ext_id(hi, lo), 1'b1, 1'b0, dlc);
      rd(offs[2], {16'h0, 4'h8, 8'h0, dlc}, "frame stored");
      $display("test receive done");
      // Remote frame to transmit object 1, answer enabled then disabled
      for (int en = 1; en >= 0; en--) begin
         bus(1'b1, offs[4], {3'b001, hi});
         bus(1'b1, offs[5], {6'h0, en[0], 5'h0, dlc});
         can_far_node_inst.hold <= 1'b1;
         can_far_node_inst.send(std_id(hi), 1'b0, 1'b1, dlc);
         repeat (3) @(posedge clock);
         check("remote answer", {tx_valid, en[0] ? tx_obj : 1'b1}, {en[0], 1'b1});
         can_far_node_inst.hold <= 1'b0;
         wait_tx(1'b0);
         rd(offs[5], {22'h0, en[0], 5'h0, dlc}, "remote control");
      end
      $display("test remote answer done");
      // Receive object 0 with request offers a remote frame
      can_far_node_inst.hold <= 1'b1;
      bus(1'b1, offs[2], {12'h010, dlc});
      wait_tx(1'b1);
      check("remote request", {tx_id, tx_remote, tx_obj},
            {ext_id(hi, lo), 1'b1, 1'b0});
      can_far_node_inst.hold <= 1'b0;
      wait_tx(1'b0);
      $display("test remote request done");
      complete_run();
   end
endmodule
